//--- rtl/sysiu_blocker.v
// Stop or wait instruction gate with lockable two-bit blocking field
`include "sysiu_map.vh"

module sysiu_blocker (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       sys_rst_b,
    input  wire       wr_en,
    input  wire [1:0] wr_value,
    input  wire       instr_req,
    output reg  [1:0] field,
    output reg        mode_enter
);

    // ****************************************************************
    // Field with write lock
    // ****************************************************************
    wire locked;
    assign locked = field[1];

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            field      <= `SYSIU_BLK_ALLOW;
            mode_enter <= 1'b0;
        end else if (!sys_rst_b) begin
            field      <= `SYSIU_BLK_ALLOW;
            mode_enter <= 1'b0;
        end else begin
            if (wr_en && !locked) begin
                field <= wr_value;
            end
            mode_enter <= instr_req && (field == `SYSIU_BLK_ALLOW);
        end
    end

endmodule

//--- rtl/sysiu_map.vh
// Register offsets, field positions and reset values of the system integration unit
`ifndef SYSIU_MAP_VH
`define SYSIU_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SYSIU_IDX_CONTROL   4'h0
`define SYSIU_IDX_RSTSTS    4'h1
`define SYSIU_IDX_SCR0      4'h2
`define SYSIU_IDX_SCR3      4'h5
`define SYSIU_IDX_ID_HIGH   4'h6
`define SYSIU_IDX_ID_LOW    4'h7
`define SYSIU_IDX_PULLUP    4'h8
`define SYSIU_IDX_RESERVED  4'h9
`define SYSIU_IDX_CLOCK_OUT_SOURCE_SEL   4'hA
`define SYSIU_IDX_GPIOSEL   4'hB
`define SYSIU_IDX_PCE       4'hC
`define SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_HIGH 4'hD
`define SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW  4'hE
`define SYSIU_IDX_MODE_STAT 4'hF

// ****************************************************************
// Control register fields
// ****************************************************************
`define SYSIU_CTL_DBG_BIT   5
`define SYSIU_CTL_SWR_BIT   4
`define SYSIU_CTL_STOP_HI   3
`define SYSIU_CTL_STOP_LO   2
`define SYSIU_CTL_WAIT_HI   1
`define SYSIU_CTL_WAIT_LO   0
`define SYSIU_BLK_ALLOW     2'h0
`define SYSIU_BLK_SOFT      2'h1

// ****************************************************************
// Reset status fields
// ****************************************************************
`define SYSIU_RS_SWR_BIT    5
`define SYSIU_RS_COP_BIT    4
`define SYSIU_RS_EXT_BIT    3
`define SYSIU_RS_POR_BIT    2

// ****************************************************************
// Write masks and fixed read values
// ****************************************************************
`define SYSIU_MASK_PULLUP   16'h7FA8
`define SYSIU_MASK_CLOCK_OUT_SOURCE_SEL  16'h03FF
`define SYSIU_MASK_GPIOSEL  16'h000F
`define SYSIU_MASK_ISALH    16'h0003
`define SYSIU_ONES_ISALH    16'hFFFC
`define SYSIU_RST_PCE       16'h0000
`define SYSIU_RST_CLOCK_OUT_SOURCE_SEL   16'h0000
`define SYSIU_RST_ISALH     16'h0003
`define SYSIU_RST_ISALL     16'hFFFF
`define SYSIU_ID_HIGH_VAL   16'h0A5A
`define SYSIU_ID_LOW_VAL    16'h0C3C
`define SYSIU_ZERO16        16'h0000
`define SYSIU_RST_FLAGS     4'h1

`endif

//--- rtl/sysiu_regs.v
// APB register bank of the system integration unit
//
// Implementation choice: the APB slave port.
`include "sysiu_map.vh"

module sysiu_regs (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        pin_reset_b,
    input  wire        watchdog_reset,
    input  wire        core_tap_enabled,
    input  wire        stop_instr,
    input  wire        wait_instr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [5:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         debug_clock_enable,
    output reg         soft_reset_req,
    output reg         stop_mode_enter,
    output reg         wait_mode_enter,
    output reg         system_reset_b,
    output reg  [15:0] pullup_disable,
    output reg  [15:0] clock_out_select,
    output reg  [15:0] gpio_peripheral_select,
    output reg  [15:0] peripheral_clock_enable,
    output reg  [15:0] short_addr_high,
    output reg  [15:0] short_addr_low
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire [3:0]  idx;
    wire        access;
    wire        wr;
    wire        mapped;
    wire [15:0] wdat;
    wire        wr_low;
    wire        wr_high;
    wire [3:0]  scr_off;

    assign idx     = paddr[5:2];
    assign access  = psel && penable && pready;
    assign wr      = access && pwrite;
    assign wr_low  = pstrb[0];
    assign wr_high = pstrb[1];
    assign wdat    = pwdata[15:0];
    assign mapped  = (idx != `SYSIU_IDX_RESERVED);
    assign scr_off = idx - `SYSIU_IDX_SCR0;

    // ****************************************************************
    // System reset sequencing
    // ****************************************************************
    // Non-power-on reset lasts as long as its cause inside this block, one cycle for a soft reset; the real
    // reset distributor stretches it for the rest of the chip.
    reg soft_pending;
    reg wdog_pending;
    reg pin_pending;
    wire any_cause;
    assign any_cause = soft_reset_req || watchdog_reset || !pin_reset_b;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            system_reset_b <= 1'b1;
        end else begin
            system_reset_b <= !any_cause;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    reg        dbg_force;
    wire [1:0] stop_field;
    wire [1:0] wait_field;
    wire       ctl_wr;
    wire       stop_enter_w;
    wire       wait_enter_w;

    assign ctl_wr = wr && (idx == `SYSIU_IDX_CONTROL) && wr_low;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dbg_force          <= 1'b0;
            soft_reset_req     <= 1'b0;
            debug_clock_enable <= 1'b0;
        end else begin
            if (!system_reset_b) begin
                dbg_force <= 1'b0;
            end else if (ctl_wr) begin
                dbg_force <= wdat[`SYSIU_CTL_DBG_BIT];
            end
            // One-cycle trigger, zero write does nothing
            soft_reset_req <= ctl_wr && wdat[`SYSIU_CTL_SWR_BIT];
            // Registered so the debug clock gate sees no glitch; lags one cycle
            debug_clock_enable <= dbg_force || core_tap_enabled;
        end
    end

    sysiu_blocker u_stop (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .sys_rst_b  (system_reset_b),
        .wr_en      (ctl_wr),
        .wr_value   (wdat[`SYSIU_CTL_STOP_HI:`SYSIU_CTL_STOP_LO]),
        .instr_req  (stop_instr),
        .field      (stop_field),
        .mode_enter (stop_enter_w)
    );

    sysiu_blocker u_wait (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .sys_rst_b  (system_reset_b),
        .wr_en      (ctl_wr),
        .wr_value   (wdat[`SYSIU_CTL_WAIT_HI:`SYSIU_CTL_WAIT_LO]),
        .instr_req  (wait_instr),
        .field      (wait_field),
        .mode_enter (wait_enter_w)
    );

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stop_mode_enter <= 1'b0;
            wait_mode_enter <= 1'b0;
        end else begin
            stop_mode_enter <= stop_enter_w;
            wait_mode_enter <= wait_enter_w;
        end
    end

    // ****************************************************************
    // Reset cause status
    // ****************************************************************
    // Causes are remembered while the system reset is low, so a flag
    // reflects the reset that just happened.
    reg  [3:0] cause_flags;
    wire       rs_wr;
    assign rs_wr = wr && (idx == `SYSIU_IDX_RSTSTS) && wr_low;

    // ****************************************************************
    // Reset cause capture
    // ****************************************************************
    // One cycle of delay lines each of the pin, watchdog and soft reset flags up with the end of its reset pulse

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            soft_pending <= 1'b0;
            wdog_pending <= 1'b0;
            pin_pending  <= 1'b0;
        end else begin
            soft_pending <= soft_reset_req;
            wdog_pending <= watchdog_reset;
            pin_pending  <= !pin_reset_b;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // Only the power-on reset sets the power-on flag
            cause_flags <= `SYSIU_RST_FLAGS;
        end else begin
            // Set wins over a same-cycle write-one clear
            if (rs_wr && wdat[`SYSIU_RS_POR_BIT]) begin
                cause_flags[0] <= 1'b0;
            end
            if (rs_wr && wdat[`SYSIU_RS_EXT_BIT]) begin
                cause_flags[1] <= 1'b0;
            end
            if (rs_wr && wdat[`SYSIU_RS_COP_BIT]) begin
                cause_flags[2] <= 1'b0;
            end
            if (rs_wr && wdat[`SYSIU_RS_SWR_BIT]) begin
                cause_flags[3] <= 1'b0;
            end
            if (pin_pending) begin
                cause_flags[1] <= 1'b1;
            end
            if (wdog_pending) begin
                cause_flags[2] <= 1'b1;
            end
            if (soft_pending) begin
                cause_flags[3] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Scratch words, only power-on clears them
    // ****************************************************************
    reg [15:0] scratch [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_scr
            always @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    scratch[g] <= `SYSIU_ZERO16;
                end else if (wr && (idx == `SYSIU_IDX_SCR0 + g)) begin
                    if (wr_low) begin
                        scratch[g][7:0] <= wdat[7:0];
                    end
                    if (wr_high) begin
                        scratch[g][15:8] <= wdat[15:8];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Plain configuration registers
    // ****************************************************************
    wire [15:0] bmask;
    assign bmask = {{8{wr_high}}, {8{wr_low}}};

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pullup_disable          <= `SYSIU_ZERO16;
            clock_out_select        <= `SYSIU_RST_CLOCK_OUT_SOURCE_SEL;
            gpio_peripheral_select  <= `SYSIU_ZERO16;
            peripheral_clock_enable <= `SYSIU_RST_PCE;
            short_addr_high         <= `SYSIU_RST_ISALH | `SYSIU_ONES_ISALH;
            short_addr_low          <= `SYSIU_RST_ISALL;
        end else if (!system_reset_b) begin
            pullup_disable          <= `SYSIU_ZERO16;
            clock_out_select        <= `SYSIU_RST_CLOCK_OUT_SOURCE_SEL;
            gpio_peripheral_select  <= `SYSIU_ZERO16;
            peripheral_clock_enable <= `SYSIU_RST_PCE;
            short_addr_high         <= `SYSIU_RST_ISALH | `SYSIU_ONES_ISALH;
            short_addr_low          <= `SYSIU_RST_ISALL;
        end else if (wr) begin
            case (idx)
                // Reserved pull-up bits stay zero whatever is written
                `SYSIU_IDX_PULLUP: begin
                    pullup_disable <= (pullup_disable & ~(bmask & `SYSIU_MASK_PULLUP))
                                    | (wdat & bmask & `SYSIU_MASK_PULLUP);
                end
                `SYSIU_IDX_CLOCK_OUT_SOURCE_SEL: begin
                    clock_out_select <= (clock_out_select & ~(bmask & `SYSIU_MASK_CLOCK_OUT_SOURCE_SEL))
                                      | (wdat & bmask & `SYSIU_MASK_CLOCK_OUT_SOURCE_SEL);
                end
                // Only the low byte holds select bits
                `SYSIU_IDX_GPIOSEL: begin
                    gpio_peripheral_select <= (wdat & `SYSIU_MASK_GPIOSEL) & {16{wr_low}}
                                            | (gpio_peripheral_select
                                               & {16{!wr_low}});
                end
                `SYSIU_IDX_PCE: begin
                    peripheral_clock_enable <= (peripheral_clock_enable & ~bmask)
                                             | (wdat & bmask);
                end
                // Upper bits are wired high; only two address bits store
                `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_HIGH: begin
                    if (wr_low) begin
                        short_addr_high <= `SYSIU_ONES_ISALH
                                         | (wdat & `SYSIU_MASK_ISALH);
                    end
                end
                `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW: begin
                    short_addr_low <= (short_addr_low & ~bmask) | (wdat & bmask);
                end
                default: begin
                    short_addr_low <= short_addr_low;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read mux and APB answer
    // ****************************************************************
    reg [15:0] rd_val;
    always @* begin
        case (idx)
            `SYSIU_IDX_CONTROL:   rd_val = {10'h000, dbg_force, 1'b0,
                                            stop_field, wait_field};
            `SYSIU_IDX_RSTSTS:    rd_val = {10'h000, cause_flags[3], cause_flags[2],
                                            cause_flags[1], cause_flags[0], 2'h0};
            `SYSIU_IDX_ID_HIGH:   rd_val = `SYSIU_ID_HIGH_VAL;
            `SYSIU_IDX_ID_LOW:    rd_val = `SYSIU_ID_LOW_VAL;
            `SYSIU_IDX_PULLUP:    rd_val = pullup_disable;
            `SYSIU_IDX_CLOCK_OUT_SOURCE_SEL:   rd_val = clock_out_select;
            `SYSIU_IDX_GPIOSEL:   rd_val = gpio_peripheral_select;
            `SYSIU_IDX_PCE:       rd_val = peripheral_clock_enable;
            `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_HIGH: rd_val = short_addr_high;
            `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW:  rd_val = short_addr_low;
            `SYSIU_IDX_MODE_STAT: rd_val = {14'h0000, stop_mode_enter, wait_mode_enter};
            default: begin
                if (idx >= `SYSIU_IDX_SCR0 && idx <= `SYSIU_IDX_SCR3) begin
                    rd_val = scratch[scr_off[1:0]];
                end else begin
                    rd_val = `SYSIU_ZERO16;
                end
            end
        endcase
    end

    // Reserved index answers with an error so a stray pointer is noticed
    // One wait state: pready rises in the second access cycle
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite && mapped) begin
                prdata <= {16'h0000, rd_val};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule

//--- sim/sysiu_core_model.sv
// Core-side model: stop and wait pulses, TAP state and reset sources
module sysiu_core_model (
    input  wire logic clk_sys,
    input  wire logic stop_mode_enter,
    input  wire logic wait_mode_enter,
    output logic      stop_instr,
    output logic      wait_instr,
    output logic      core_tap_enabled,
    output logic      watchdog_reset,
    output logic      pin_reset_b,
    output int        stop_seen,
    output int        wait_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Core behaviour
    // ****************************************
    initial begin
        {stop_instr, wait_instr, core_tap_enabled, watchdog_reset} = 4'h0;
        pin_reset_b = 1'b1;
        stop_seen = 0;
        wait_seen = 0;
    end
    // Entries are counted as the core would see its clock being stopped
    always @(posedge clk_sys) begin
        stop_seen <= stop_seen + (stop_mode_enter === 1'b1);
        wait_seen <= wait_seen + (wait_mode_enter === 1'b1);
    end
    // Kind 0 stop, 1 wait, 2 watchdog, 3 reset pin; one cycle each
    task automatic pulse(input int kind);
        @(posedge clk_sys);
        stop_instr <= (kind == 0);
        wait_instr <= (kind == 1);
        watchdog_reset <= (kind == 2);
        pin_reset_b <= (kind != 3);
        @(posedge clk_sys);
        {stop_instr, wait_instr, watchdog_reset} <= 3'h0;
        pin_reset_b <= 1'b1;
    endtask
    task automatic set_tap(input logic v);
        @(posedge clk_sys);
        core_tap_enabled <= v;
    endtask
endmodule

//--- sim/sysiu_regs_props.sv
// Concurrent checks on the ports of the system integration register bank
module sysiu_regs_props (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        watchdog_reset,
    input wire        core_tap_enabled,
    input wire        stop_instr,
    input wire        wait_instr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [5:0]  paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire        pslverr,
    input wire        debug_clock_enable,
    input wire        soft_reset_req,
    input wire        stop_mode_enter,
    input wire        wait_mode_enter,
    input wire        system_reset_b,
    input wire [15:0] clock_out_select,
    input wire [15:0] gpio_peripheral_select,
    input wire [15:0] short_addr_high
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Only a completed control write with bit 4 set may launch a soft reset
    wire swr_wr = psel && penable && pready && pwrite && pstrb[0]
                  && paddr[5:2] == 4'h0 && pwdata[4];
    // ****************************************
    // Assertions
    // ****************************************
    a_one_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("no answer after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_dbg_tap: assert property ($past(rst_b) && $past(core_tap_enabled) |-> debug_clock_enable)
        else $error("debug clock off with TAP on");
    a_stop_cause: assert property (stop_mode_enter |-> $past(stop_instr, 2))
        else $error("stop entry without instruction");
    a_wait_cause: assert property (wait_mode_enter |-> $past(wait_instr, 2))
        else $error("wait entry without instruction");
    a_soft_cause: assert property ($rose(soft_reset_req) |-> $past(swr_wr) || $past(swr_wr, 2))
        else $error("soft reset without write");
    a_soft_sys: assert property (soft_reset_req |=> !system_reset_b)
        else $error("soft reset not applied");
    a_wdog_sys: assert property ($rose(watchdog_reset) |-> ##[1:3] !system_reset_b)
        else $error("watchdog reset not applied");
    a_sys_clear: assert property (!system_reset_b |-> ##[1:2] gpio_peripheral_select == 16'h0000)
        else $error("gpio select kept over reset");
    a_gpio_upper: assert property (gpio_peripheral_select[15:4] == 12'h000)
        else $error("gpio select upper bits set");
    a_clock_output_pin_upper: assert property (clock_out_select[15:10] == 6'h00)
        else $error("clock-out upper bits set");
    a_short_io_address_location_ones: assert property (short_addr_high[15:2] == 14'h3FFF)
        else $error("short address upper bits not ones");
endmodule

bind sysiu_regs sysiu_regs_props u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .watchdog_reset(watchdog_reset),
    .core_tap_enabled(core_tap_enabled), .stop_instr(stop_instr), .wait_instr(wait_instr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .debug_clock_enable(debug_clock_enable), .soft_reset_req(soft_reset_req),
    .stop_mode_enter(stop_mode_enter), .wait_mode_enter(wait_mode_enter),
    .system_reset_b(system_reset_b), .clock_out_select(clock_out_select),
    .gpio_peripheral_select(gpio_peripheral_select), .short_addr_high(short_addr_high)
);

//--- sim/tb_top.sv
// Self-checking bench for the system integration register bank
`include "sysiu_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, dbg, soft_reset_flag, stp, wte, sys_b;
    logic        stop_instr, wait_instr, tap, watchdog_reset, pin_reset_b;
    logic [15:0] pud, cko, gps, pce, sah, sal;
    int          stop_seen, wait_seen;
    int          err_count = 0;
    int          checked = 0;
    logic [3:0]  t_idx [8] = '{`SYSIU_IDX_SCR0, `SYSIU_IDX_SCR3, `SYSIU_IDX_GPIOSEL,
        `SYSIU_IDX_CLOCK_OUT_SOURCE_SEL, `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_HIGH, `SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW, `SYSIU_IDX_PCE,
        `SYSIU_IDX_PULLUP};
    logic [15:0] t_wd [8] = '{16'hA55A, 16'h5AA5, 16'hFFFF, 16'hFFFF, 16'h0002, 16'h1234,
        16'hFFFF, 16'hFFFF};
    logic [15:0] t_exp [8] = '{16'hA55A, 16'h5AA5, 16'h000F, 16'h03FF, 16'hFFFE, 16'h1234,
        16'hFFFF, `SYSIU_MASK_PULLUP};

    always #10 clk_sys = ~clk_sys;

    sysiu_regs DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .pin_reset_b(pin_reset_b),
        .watchdog_reset(watchdog_reset), .core_tap_enabled(tap), .stop_instr(stop_instr),
        .wait_instr(wait_instr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_clock_enable(dbg), .soft_reset_req(soft_reset_flag),
        .stop_mode_enter(stp), .wait_mode_enter(wte), .system_reset_b(sys_b),
        .pullup_disable(pud), .clock_out_select(cko), .gpio_peripheral_select(gps),
        .peripheral_clock_enable(pce), .short_addr_high(sah), .short_addr_low(sal)
    );
    sysiu_core_model core (
        .clk_sys(clk_sys), .stop_mode_enter(stp), .wait_mode_enter(wte),
        .stop_instr(stop_instr), .wait_instr(wait_instr), .core_tap_enabled(tap),
        .watchdog_reset(watchdog_reset), .pin_reset_b(pin_reset_b),
        .stop_seen(stop_seen), .wait_seen(wait_seen)
    );
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic give_verdict();
        $display("checked %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic [3:0] idx, input logic w, input logic [15:0] wd,
                       output logic [31:0] rv, output logic ev);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk1(pready, 1'b1);
        if (pready !== 1'b1) give_verdict();
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [15:0] wd);
        apb(idx, 1'b1, wd, rd, er);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [15:0] exp);
        apb(idx, 1'b0, 16'h0000, rd, er);
        check(rd, {16'h0000, exp});
    endtask
    task automatic ctl(input logic [15:0] wd, input logic [15:0] exp);
        wr(`SYSIU_IDX_CONTROL, wd);
        rdc(`SYSIU_IDX_CONTROL, exp);
    endtask
    // Both instructions every time, so a swapped field shows in a count
    task automatic modes(input int s, input int w);
        core.pulse(0);
        core.pulse(1);
        repeat (4) @(posedge clk_sys);
        check(stop_seen, s);
        check(wait_seen, w);
    endtask
    task automatic wait_sysrst();
        int n;
        n = 0;
        while (sys_b !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk1(sys_b, 1'b0);
        if (sys_b !== 1'b0) give_verdict();
        repeat (3) @(posedge clk_sys);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(`SYSIU_IDX_RSTSTS, 16'h0004);
        rdc(`SYSIU_IDX_ID_HIGH, `SYSIU_ID_HIGH_VAL);
        wr(`SYSIU_IDX_ID_LOW, 16'hFFFF);
        rdc(`SYSIU_IDX_ID_LOW, `SYSIU_ID_LOW_VAL);
        for (int i = 0; i < 8; i++) begin
            wr(t_idx[i], t_wd[i]);
            rdc(t_idx[i], t_exp[i]);
        end
        check({pud, cko}, {`SYSIU_MASK_PULLUP, 16'h03FF});
        check({gps, pce}, 32'h000FFFFF);
        check({sah, sal}, 32'hFFFE1234);
        pstrb <= 4'h2;
        wr(`SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW, 16'hABCD);
        pstrb <= 4'hF;
        rdc(`SYSIU_IDX_SHORT_IO_ADDRESS_LOCATION_LOW, 16'hAB34);
        modes(1, 1);
        ctl(16'h0005, 16'h0005);
        modes(1, 1);
        ctl(16'h0008, 16'h0008);
        ctl(16'h0004, 16'h0008);
        modes(1, 2);
        chk1(dbg, 1'b0);
        core.set_tap(1'b1);
        repeat (3) @(posedge clk_sys);
        chk1(dbg, 1'b1);
        core.set_tap(1'b0);
        ctl(16'hFFE0, 16'h0028);
        chk1(dbg, 1'b1);
        wr(`SYSIU_IDX_CONTROL, 16'h0030);
        wait_sysrst();
        rdc(`SYSIU_IDX_CONTROL, 16'h0000);
        check({pud, cko}, 32'h00000000);
        check({gps, pce}, 32'h00000000);
        check({sah, sal}, 32'hFFFFFFFF);
        chk1(dbg, 1'b0);
        rdc(`SYSIU_IDX_RSTSTS, 16'h0024);
        rdc(`SYSIU_IDX_SCR0, 16'hA55A);
        ctl(16'h000C, 16'h000C);
        ctl(16'h0000, 16'h000C);
        modes(1, 3);
        wr(`SYSIU_IDX_RSTSTS, 16'h003C);
        rdc(`SYSIU_IDX_RSTSTS, 16'h0000);
        core.pulse(2);
        wait_sysrst();
        rdc(`SYSIU_IDX_RSTSTS, 16'h0010);
        core.pulse(3);
        wait_sysrst();
        rdc(`SYSIU_IDX_RSTSTS, 16'h0018);
        rdc(`SYSIU_IDX_SCR3, 16'h5AA5);
        apb(4'h9, 1'b1, 16'hFFFF, rd, er);
        chk1(er, 1'b1);
        apb(4'h9, 1'b0, 16'h0000, rd, er);
        check(rd, 32'h00000000);
        give_verdict();
    end
endmodule
